// *** verilog/gaf_amp_regs.sv ***
// control registers of the gas sensor front end amplifier, reached over axi4-lite
//
// Function
// - bandwidth code 00/01/10/11 selects 5 kHz, 40 kHz, 600 kHz, 2 MHz.
// - unused bits of control and upper resistor registers read as zero.
// - trim register bit 7 selects normal or offset calibration mode.
// - trim register bit 6 selects inverting or non-inverting calibration reference.
// - trim register bits 5..0 hold the writable offset trim code.
// - 9-bit resistor code; resistance 1915k minus 5k per step of the low 8 bits minus 640k when bit 8 is set.
// - comparator status bit follows amplifier output in calibration, else zero.
// - control register holds enable, bandwidth field and comparator status bit.
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register addresses.
`include "gaf_amp_map.svh"

module gaf_amp_regs
(
    input  wire logic                   mclk,
    input  wire logic                   rst_n,
    // register bus
    input  wire logic [`GAF_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [`GAF_DATA_W-1:0] s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    input  wire logic [`GAF_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [`GAF_DATA_W-1:0]      s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    // comparator level from the amplifier output
    input  wire logic                   amp_out_level,
    // analog controls
    output logic                        amp_enable,
    output logic [1:0]                  amp_bandwidth_sel,
    output logic [3:0]                  amp_bw_onehot,
    output logic                        offset_cal_mode,
    output logic                        cal_reference_sel,
    output logic [5:0]                  offset_trim_code,
    output logic [7:0]                  res_code_low_bits,
    output logic                        res_code_high_bit,
    output logic [`GAF_RES_KOHM_W-1:0]  feedback_res_kohm
);

    gaf_pkg::gaf_regs_t r_q;
    gaf_pkg::gaf_regs_t r_d;

    logic                   wr_en;
    logic [`GAF_ADDR_W-1:0] wr_addr;
    logic [7:0]             wr_data;
    logic                   wr_strb0;
    logic                   wr_err;
    logic [`GAF_ADDR_W-1:0] rd_addr;
    logic [`GAF_DATA_W-1:0] rd_data;
    logic                   rd_err;
    logic                   amp_compare_status;

    // bus front end
    gaf_axil_slave u_bus
    (
        .mclk          (mclk),
        .rst_n         (rst_n),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .wr_en         (wr_en),
        .wr_addr       (wr_addr),
        .wr_data       (wr_data),
        .wr_strb0      (wr_strb0),
        .wr_err        (wr_err),
        .rd_addr       (rd_addr),
        .rd_data       (rd_data),
        .rd_err        (rd_err)
    );

    // address decode: anything but the four words is unmapped
    always_comb
    begin
        wr_err = 1'b1;
        unique case (wr_addr)
            `GAF_OFS_AMP_CTRL,
            `GAF_OFS_OFFSET_TRIM,
            `GAF_OFS_RES_LOW,
            `GAF_OFS_RES_HIGH: wr_err = 1'b0;
            default:           wr_err = 1'b1;
        endcase
    end

    // comparator shows only in calibration mode
    assign amp_compare_status = r_q.offset_cal_mode & amp_out_level;

    // read mux, unused bits tied low
    always_comb
    begin
        rd_data = '0;
        rd_err  = 1'b0;
        unique case (rd_addr)
            `GAF_OFS_AMP_CTRL:
            begin
                rd_data[`GAF_CTRL_EN_BIT]     = r_q.amp_enable;
                rd_data[`GAF_CTRL_STATUS_BIT] = amp_compare_status;
                rd_data[`GAF_CTRL_BW_LSB +: `GAF_CTRL_BW_W] = r_q.amp_bandwidth_sel;
            end
            `GAF_OFS_OFFSET_TRIM:
            begin
                rd_data[`GAF_TRIM_MODE_BIT] = r_q.offset_cal_mode;
                rd_data[`GAF_TRIM_REF_BIT]  = r_q.cal_reference_sel;
                rd_data[`GAF_TRIM_CODE_LSB +: `GAF_TRIM_CODE_W] = r_q.offset_trim_code;
            end
            `GAF_OFS_RES_LOW:
            begin
                rd_data[7:0] = r_q.res_code_low_bits;
            end
            `GAF_OFS_RES_HIGH:
            begin
                rd_data[0] = r_q.res_code_high_bit;
            end
            default:
            begin
                rd_err = 1'b1;
            end
        endcase
    end

    // register writes, only byte lane 0 carries data
    always_comb
    begin
        r_d = r_q;
        if (wr_en && wr_strb0)
        begin
            unique case (wr_addr)
                `GAF_OFS_AMP_CTRL:
                begin
                    r_d.amp_enable        = wr_data[`GAF_CTRL_EN_BIT];
                    r_d.amp_bandwidth_sel = wr_data[`GAF_CTRL_BW_LSB +: `GAF_CTRL_BW_W];
                end
                `GAF_OFS_OFFSET_TRIM:
                begin
                    r_d.offset_cal_mode   = wr_data[`GAF_TRIM_MODE_BIT];
                    r_d.cal_reference_sel = wr_data[`GAF_TRIM_REF_BIT];
                    r_d.offset_trim_code  = wr_data[`GAF_TRIM_CODE_LSB +: `GAF_TRIM_CODE_W];
                end
                `GAF_OFS_RES_LOW:
                begin
                    r_d.res_code_low_bits = wr_data;
                end
                `GAF_OFS_RES_HIGH:
                begin
                    r_d.res_code_high_bit = wr_data[0];
                end
                default:
                begin
                    r_d = r_q;
                end
            endcase
        end
        // bandwidth decode to one select line per corner
        unique case (r_d.amp_bandwidth_sel)
            `GAF_BW_5KHZ:   r_d.bw_onehot = 4'h1;
            `GAF_BW_40KHZ:  r_d.bw_onehot = 4'h2;
            `GAF_BW_600KHZ: r_d.bw_onehot = 4'h4;
            `GAF_BW_2MHZ:   r_d.bw_onehot = 4'h8;
        endcase
        // feedback resistance from the 9-bit code
        r_d.res_kohm = `GAF_R_BASE_KOHM
                     - (`GAF_RES_KOHM_W'(r_d.res_code_low_bits) * `GAF_R_STEP_KOHM)
                     - (r_d.res_code_high_bit ? `GAF_R_HIGH_KOHM : 11'h000);
    end

    // state register, analog copies change the cycle after the write
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            r_q.amp_enable        <= `GAF_RST_AMP_EN;
            r_q.amp_bandwidth_sel <= `GAF_RST_BW;
            r_q.bw_onehot         <= 4'h1;
            r_q.offset_cal_mode   <= `GAF_RST_CAL_MODE;
            r_q.cal_reference_sel <= `GAF_RST_CAL_REF;
            r_q.offset_trim_code  <= `GAF_RST_TRIM_CODE;
            r_q.res_code_low_bits <= `GAF_RST_RES_LOW;
            r_q.res_code_high_bit <= `GAF_RST_RES_HIGH;
            r_q.res_kohm          <= `GAF_R_BASE_KOHM;
        end
        else
        begin
            r_q <= r_d;
        end
    end

    // analog controls straight from state
    assign amp_enable        = r_q.amp_enable;
    assign amp_bandwidth_sel = r_q.amp_bandwidth_sel;
    assign amp_bw_onehot     = r_q.bw_onehot;
    assign offset_cal_mode   = r_q.offset_cal_mode;
    assign cal_reference_sel = r_q.cal_reference_sel;
    assign offset_trim_code  = r_q.offset_trim_code;
    assign res_code_low_bits = r_q.res_code_low_bits;
    assign res_code_high_bit = r_q.res_code_high_bit;
    assign feedback_res_kohm = r_q.res_kohm;

endmodule

// *** include/gaf_amp_map.svh ***
// register offsets, field positions, reset values and constants of the amplifier control block
`ifndef GAF_AMP_MAP_SVH
`define GAF_AMP_MAP_SVH

// bus geometry
`define GAF_ADDR_W           8
`define GAF_DATA_W           32

// byte offsets of the register words
`define GAF_OFS_AMP_CTRL     8'h00
`define GAF_OFS_OFFSET_TRIM  8'h04
`define GAF_OFS_RES_LOW      8'h08
`define GAF_OFS_RES_HIGH     8'h0c

// amplifier control register fields
`define GAF_CTRL_EN_BIT      6
`define GAF_CTRL_STATUS_BIT  5
`define GAF_CTRL_BW_LSB      0
`define GAF_CTRL_BW_W        2

// offset trim register fields
`define GAF_TRIM_MODE_BIT    7
`define GAF_TRIM_REF_BIT     6
`define GAF_TRIM_CODE_LSB    0
`define GAF_TRIM_CODE_W      6

// reset values
`define GAF_RST_AMP_EN       1'b0
`define GAF_RST_BW           2'h0
`define GAF_RST_CAL_MODE     1'b0
`define GAF_RST_CAL_REF      1'b0
`define GAF_RST_TRIM_CODE    6'h20
`define GAF_RST_RES_LOW      8'h00
`define GAF_RST_RES_HIGH     1'b0

// feedback resistance in kOhm: base minus step per low code minus weight of high bit
`define GAF_RES_KOHM_W       11
`define GAF_R_BASE_KOHM      11'd1915
`define GAF_R_STEP_KOHM      11'd5
`define GAF_R_HIGH_KOHM      11'd640

// bandwidth codes
`define GAF_BW_5KHZ          2'h0
`define GAF_BW_40KHZ         2'h1
`define GAF_BW_600KHZ        2'h2
`define GAF_BW_2MHZ          2'h3

// bus responses
`define GAF_RESP_OKAY        2'h0
`define GAF_RESP_DECERR      2'h3

`endif

// *** include/gaf_pkg.sv ***
// types shared by the amplifier control register block
`include "gaf_amp_map.svh"

package gaf_pkg;

    // bus slave state
    typedef struct packed {
        logic                   awready;
        logic                   wready;
        logic                   arready;
        logic                   aw_held;
        logic                   w_held;
        logic [`GAF_ADDR_W-1:0] waddr;
        logic [7:0]             wdata;
        logic                   wstrb0;
        logic                   bvalid;
        logic [1:0]             bresp;
        logic                   rd_pend;
        logic [`GAF_ADDR_W-1:0] raddr;
        logic                   rvalid;
        logic [`GAF_DATA_W-1:0] rdata;
        logic [1:0]             rresp;
    } gaf_axil_t;

    // control register state and analog-facing copies
    typedef struct packed {
        logic                       amp_enable;
        logic [1:0]                 amp_bandwidth_sel;
        logic [3:0]                 bw_onehot;
        logic                       offset_cal_mode;
        logic                       cal_reference_sel;
        logic [5:0]                 offset_trim_code;
        logic [7:0]                 res_code_low_bits;
        logic                       res_code_high_bit;
        logic [`GAF_RES_KOHM_W-1:0] res_kohm;
    } gaf_regs_t;

endpackage

// *** verilog/gaf_axil_slave.sv ***
// axi4-lite slave front end: one write and one read at a time, registered answers
`include "gaf_amp_map.svh"

module gaf_axil_slave
(
    input  wire logic                   mclk,
    input  wire logic                   rst_n,
    input  wire logic [`GAF_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [`GAF_DATA_W-1:0] s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    input  wire logic [`GAF_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [`GAF_DATA_W-1:0]      s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    output logic                        wr_en,
    output logic [`GAF_ADDR_W-1:0]      wr_addr,
    output logic [7:0]                  wr_data,
    output logic                        wr_strb0,
    input  wire logic                   wr_err,
    output logic [`GAF_ADDR_W-1:0]      rd_addr,
    input  wire logic [`GAF_DATA_W-1:0] rd_data,
    input  wire logic                   rd_err
);

    gaf_pkg::gaf_axil_t s_q;
    gaf_pkg::gaf_axil_t s_d;

    // commit once address and data are both held and no response is pending
    assign wr_en    = s_q.aw_held & s_q.w_held & ~s_q.bvalid;
    assign wr_addr  = s_q.waddr;
    assign wr_data  = s_q.wdata;
    assign wr_strb0 = s_q.wstrb0;
    assign rd_addr  = s_q.raddr;

    // bus outputs straight from state
    assign s_axi_awready = s_q.awready;
    assign s_axi_wready  = s_q.wready;
    assign s_axi_arready = s_q.arready;
    assign s_axi_bvalid  = s_q.bvalid;
    assign s_axi_bresp   = s_q.bresp;
    assign s_axi_rvalid  = s_q.rvalid;
    assign s_axi_rdata   = s_q.rdata;
    assign s_axi_rresp   = s_q.rresp;

    // channel handshakes
    always_comb
    begin
        s_d = s_q;
        if (s_axi_awvalid && s_q.awready)
        begin
            s_d.awready = 1'b0;
            s_d.aw_held = 1'b1;
            s_d.waddr   = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_q.wready)
        begin
            s_d.wready  = 1'b0;
            s_d.w_held  = 1'b1;
            s_d.wdata   = s_axi_wdata[7:0];
            s_d.wstrb0  = s_axi_wstrb[0];
        end
        if (wr_en)
        begin
            s_d.aw_held = 1'b0;
            s_d.w_held  = 1'b0;
            s_d.bvalid  = 1'b1;
            s_d.bresp   = wr_err ? `GAF_RESP_DECERR : `GAF_RESP_OKAY;
        end
        if (s_q.bvalid && s_axi_bready)
        begin
            s_d.bvalid  = 1'b0;
            s_d.awready = 1'b1;
            s_d.wready  = 1'b1;
        end
        // read: address taken, data captured one cycle later
        if (s_axi_arvalid && s_q.arready)
        begin
            s_d.arready = 1'b0;
            s_d.raddr   = s_axi_araddr;
            s_d.rd_pend = 1'b1;
        end
        if (s_q.rd_pend)
        begin
            s_d.rd_pend = 1'b0;
            s_d.rvalid  = 1'b1;
            s_d.rdata   = rd_err ? '0 : rd_data;
            s_d.rresp   = rd_err ? `GAF_RESP_DECERR : `GAF_RESP_OKAY;
        end
        if (s_q.rvalid && s_axi_rready)
        begin
            s_d.rvalid  = 1'b0;
            s_d.arready = 1'b1;
        end
    end

    // state register
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_q         <= '0;
            s_q.awready <= 1'b1;
            s_q.wready  <= 1'b1;
            s_q.arready <= 1'b1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

endmodule

// *** tb/gaf_amp_regs_monitor.sv ***
// concurrent checks on the ports of the amplifier control register block
`include "gaf_amp_map.svh"

module gaf_amp_regs_monitor
(
    input wire logic                        mclk,
    input wire logic                        rst_n,
    input wire logic                        s_axi_awvalid,
    input wire logic                        s_axi_awready,
    input wire logic                        s_axi_wvalid,
    input wire logic                        s_axi_wready,
    input wire logic                        s_axi_bvalid,
    input wire logic                        s_axi_bready,
    input wire logic [1:0]                  s_axi_bresp,
    input wire logic [`GAF_ADDR_W-1:0]      s_axi_araddr,
    input wire logic                        s_axi_arvalid,
    input wire logic                        s_axi_arready,
    input wire logic                        s_axi_rvalid,
    input wire logic                        s_axi_rready,
    input wire logic [`GAF_DATA_W-1:0]      s_axi_rdata,
    input wire logic                        amp_out_level,
    input wire logic                        amp_enable,
    input wire logic [1:0]                  amp_bandwidth_sel,
    input wire logic [3:0]                  amp_bw_onehot,
    input wire logic                        offset_cal_mode,
    input wire logic                        cal_reference_sel,
    input wire logic [5:0]                  offset_trim_code,
    input wire logic [7:0]                  res_code_low_bits,
    input wire logic                        res_code_high_bit,
    input wire logic [`GAF_RES_KOHM_W-1:0]  feedback_res_kohm
);
    logic [`GAF_ADDR_W-1:0] raddr_q;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    // remember the address of the read under way
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            raddr_q <= '0;
        else if (s_axi_arvalid && s_axi_arready)
            raddr_q <= s_axi_araddr;
    end

    sequence wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence

    bw_decode_a: assert property (amp_bw_onehot == (4'h1 << amp_bandwidth_sel))
        else $error("bandwidth decode wrong");
    res_value_a: assert property (feedback_res_kohm == 11'd1915 - 11'd5 * res_code_low_bits
        - (res_code_high_bit ? 11'd640 : 11'd0)) else $error("resistance value wrong");
    wr_timing_a: assert property (wr_take |-> !s_axi_bvalid ##1 !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("write answer late or early");
    held_values_a: assert property (!$rose(s_axi_bvalid) |-> $stable({amp_enable, amp_bandwidth_sel,
        offset_cal_mode, cal_reference_sel, offset_trim_code, res_code_low_bits, res_code_high_bit}))
        else $error("control output moved without a write");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");
    rd_timing_a: assert property (rd_take |-> ##1 !s_axi_rvalid ##1 s_axi_rvalid)
        else $error("read answer late or early");
    rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");
    zero_bits_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0
        && (raddr_q != 8'h00 || s_axi_rdata[4:2] == 3'h0) && (raddr_q != 8'h0c || s_axi_rdata[7:1] == 7'h0))
        else $error("unused bits not zero");
    status_read_a: assert property ($rose(s_axi_rvalid) && raddr_q == 8'h00
        |-> s_axi_rdata[5] == ($past(offset_cal_mode) && $past(amp_out_level))) else $error("status bit wrong");
endmodule

bind gaf_amp_regs gaf_amp_regs_monitor i_gaf_amp_regs_monitor (.*);

// *** tb/gaf_amp_regs_tb.sv ***
// self-checking bench of the amplifier control register block
`include "gaf_amp_map.svh"

module gaf_amp_regs_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk, rst_n, amp_out_level, st, s;
    logic [`GAF_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [`GAF_DATA_W-1:0] s_axi_wdata, s_axi_rdata, seed, r;
    logic [3:0] s_axi_wstrb, amp_bw_onehot;
    logic [1:0] s_axi_bresp, s_axi_rresp, amp_bandwidth_sel;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic amp_enable, offset_cal_mode, cal_reference_sel, res_code_high_bit, m_high;
    logic [5:0] offset_trim_code, thr, code, v1;
    logic [7:0] res_code_low_bits, m_ctrl, m_trim, m_low;
    logic [`GAF_RES_KOHM_W-1:0] feedback_res_kohm;
    int miscompares, cmp_count;

    gaf_amp_regs i_gaf_amp_regs (.*);

    // clock and comparator behaviour: output high above a hidden threshold
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk) amp_out_level <= offset_trim_code > thr;

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        return a inside {`GAF_OFS_AMP_CTRL, `GAF_OFS_OFFSET_TRIM, `GAF_OFS_RES_LOW, `GAF_OFS_RES_HIGH};
    endfunction

    // expected read word from the model
    function automatic logic [31:0] exp_rd(input logic [7:0] a);
        case (a)
            `GAF_OFS_AMP_CTRL: return {25'h0, m_ctrl[6], m_trim[7] & (m_trim[5:0] > thr), 3'h0, m_ctrl[1:0]};
            `GAF_OFS_OFFSET_TRIM: return {24'h0, m_trim};
            `GAF_OFS_RES_LOW: return {24'h0, m_low};
            `GAF_OFS_RES_HIGH: return {31'h0, m_high};
            default: return 32'h0;
        endcase
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // analog-facing outputs against the model
    task automatic out_chk();
        chk({amp_enable, amp_bandwidth_sel, offset_cal_mode, cal_reference_sel, offset_trim_code,
            res_code_low_bits, res_code_high_bit}, {m_ctrl[6], m_ctrl[1:0], m_trim, m_low, m_high});
        chk(amp_bw_onehot, 4'h1 << m_ctrl[1:0]);
        chk(feedback_res_kohm, 1915 - 5 * m_low - 640 * m_high);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] sb);
        logic hs;
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= sb;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= seed[0];  // sometimes late, so a held answer is seen
        do
        begin
            @(posedge mclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            hs = s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1;
            s_axi_bready <= !hs && (s_axi_bready || s_axi_bvalid === 1'b1);
        end
        while (!hs);
        chk(s_axi_bresp, mapped(a) ? 2'h0 : 2'h3);
        if (sb[0])
            case (a)
                `GAF_OFS_AMP_CTRL: m_ctrl = d[7:0] & 8'h43;
                `GAF_OFS_OFFSET_TRIM: m_trim = d[7:0];
                `GAF_OFS_RES_LOW: m_low = d[7:0];
                `GAF_OFS_RES_HIGH: m_high = d[0];
                default: ;
            endcase
        out_chk();
    endtask

    task automatic rd(input logic [7:0] a);
        logic hs;
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= seed[1];  // sometimes late, so held read data is seen
        do
        begin
            @(posedge mclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            hs = s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1;
            s_axi_rready <= !hs && (s_axi_rready || s_axi_rvalid === 1'b1);
        end
        while (!hs);
        chk(s_axi_rdata, exp_rd(a));
        chk(s_axi_rresp, mapped(a) ? 2'h0 : 2'h3);
        st = s_axi_rdata[5];
    endtask

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // watchdog against a hung handshake
    initial
    begin
        repeat (30000) @(posedge mclk);
        miscompares++;
        stop_test();
    end

    initial
    begin
        {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        {m_ctrl, m_low, m_high} = '0;
        m_trim = 8'h20;
        seed = 32'd9961;
        thr = 6'(rnd() % 63);
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        out_chk();
        for (int i = 0; i < 8; i++) rd(8'(i * 4));
        for (int i = 0; i < 5; i++)
        begin
            wr(8'(i * 4), 32'hffffffff, 4'hf);
            rd(8'(i * 4));
        end
        for (int b = 0; b < 4; b++) wr(`GAF_OFS_AMP_CTRL, 32'(b), 4'h1);
        // random traffic, unmapped places and disabled lanes among it
        repeat (40)
        begin
            r = rnd();
            wr({3'h0, r[4:2], 2'h0}, rnd(), {3'h0, r[9:8] != 2'h0});
            rd({3'h0, r[4:2], 2'h0});
        end
        // offset calibration sweep as software runs it
        wr(`GAF_OFS_AMP_CTRL, 32'h40, 4'h1);
        wr(`GAF_OFS_OFFSET_TRIM, 32'h80, 4'h1);
        rd(`GAF_OFS_AMP_CTRL);
        s = st;
        code = 6'h0;
        do
        begin
            code++;
            wr(`GAF_OFS_OFFSET_TRIM, {26'h2, code}, 4'h1);
            rd(`GAF_OFS_AMP_CTRL);
        end
        while (st === s && code != 6'h3f);
        v1 = code;
        wr(`GAF_OFS_OFFSET_TRIM, 32'hbf, 4'h1);
        rd(`GAF_OFS_AMP_CTRL);
        s = st;
        code = 6'h3f;
        do
        begin
            code = code - 6'h1;
            wr(`GAF_OFS_OFFSET_TRIM, {26'h2, code}, 4'h1);
            rd(`GAF_OFS_AMP_CTRL);
        end
        while (st === s && code != 6'h0);
        wr(`GAF_OFS_OFFSET_TRIM, 32'((7'(v1) + 7'(code)) >> 1), 4'h1);
        chk(offset_trim_code, thr);
        rd(`GAF_OFS_AMP_CTRL);
        stop_test();
    end
endmodule
